// file: src/acs_cmd_status_regs.sv
// command-mode control and status registers of one sensor channel
// assumes link framing/bit timing is decoded outside into cmd/data strobes,
// and a memory port answering reads with a one-cycle-or-later rvalid
`include "acs_params.svh"

module acs_cmd_status_regs #(
    parameter int ENTRY_TIME_US = `ACS_ENTRY_TIME_US,
    parameter int PROG_TIME_US  = `ACS_PROG_TIME_US
) (
    // clock and reset
    input  wire logic            ref_clk,
    input  wire logic            rst,
    // decoded link transactions
    input  wire logic            cmd_valid,
    input  wire logic [7:0]      cmd_byte,
    input  wire acs_pkg::acs_word_t cmd_wdata,
    output logic                 rsp_valid,
    output acs_pkg::acs_word_t   rsp_data,
    // sensor conditions
    input  wire logic            undervoltage_in,
    input  wire logic            field_loss_in,
    input  wire logic            field_loss_detect_en,
    // non-volatile memory port
    output logic                 mem_rd,
    output logic                 mem_wr,
    output logic [3:0]           mem_addr,
    output acs_pkg::acs_word_t   mem_wdata,
    input  wire logic            mem_rvalid,
    input  wire acs_pkg::acs_word_t mem_rdata,
    input  wire logic            mem_single_err,
    input  wire logic            mem_double_err,
    // mode and status outputs
    output logic                 command_mode,
    output logic                 analog_out_enable,
    output logic                 diag_output_active,
    output logic                 prog_busy,
    output logic                 pump_clock_enable,
    output logic                 memory_write_enable
);
    import acs_pkg::*;

    // time figures turned into cycles; window is a longest time, so rounds down
    localparam int ENTRY_CYCLES = ENTRY_TIME_US * `ACS_CLK_MHZ;
    localparam int PROG_CYCLES  = PROG_TIME_US * `ACS_CLK_MHZ;

    acs_mode_t   mode;               // start-up mode
    acs_scan_t   scan;               // checksum scan state
    logic [31:0] entry_cnt;          // cycles since reset, held once the wait mode ends
    logic [31:0] prog_cnt;           // programming cycles left
    logic [3:0]  scan_addr;          // next word of the scan
    logic [7:0]  crc;                // running checksum
    logic        diagnostic_suppress;
    logic        undervoltage_flag;
    logic        single_bit_flag;
    logic        double_bit_flag;
    logic        field_loss_flag;
    logic        crc_bad;
    logic        diagnostic_present;
    logic        link_rd_pend;       // link read waiting on memory
    logic        is_reg;             // command selects register region
    logic        is_nvm;             // command selects memory region
    logic        is_read;
    logic [3:0]  cmd_addr;
    logic        take;               // command honoured in current mode
    acs_word_t   status_and_control; // read view of the status word
    acs_word_t   memory_write_control;
    logic        key_ok;

    // one checksum step per 16-bit word, msb first
    function automatic logic [7:0] crc_word(input logic [7:0] c, input acs_word_t d);
        logic [7:0] r;
        logic       fb;
        r = c;
        for (int i = 15; i >= 0; i--)
        begin
            fb = r[7];
            r  = {r[6:0], d[i]} ^ (fb ? `ACS_CRC_POLY_LOW : 8'h00); // R18
        end
        return r;
    endfunction : crc_word

    // command byte fields
    assign is_reg   = cmd_byte[7:5] == `ACS_REGION_REG; // R19
    assign is_nvm   = cmd_byte[7:5] == `ACS_REGION_NVM;
    assign is_read  = cmd_byte[0];
    assign cmd_addr = cmd_byte[4:1];
    // key write may also come while the part sits in diagnostic mode
    assign key_ok   = cmd_valid && is_reg && !is_read && cmd_addr == `ACS_ADDR_KEY
                      && cmd_wdata == `ACS_KEY_VALUE;
    // outside command mode nothing but the key is understood
    assign take     = cmd_valid && mode == MODE_CMD;

    // live diagnostic condition, suppress does not mask it
    assign diagnostic_present = (field_loss_in && field_loss_detect_en) // R9
                                || double_bit_flag || crc_bad || undervoltage_flag; // R3
    assign diag_output_active = diagnostic_present && !diagnostic_suppress; // R4
    assign analog_out_enable  = mode != MODE_CMD; // R20
    assign command_mode       = mode == MODE_CMD;
    assign prog_busy          = prog_cnt != 32'h0;

    // readable words; reserved and write-only bits read zero
    always_comb
    begin
        status_and_control = 16'h0000; // R21
        status_and_control[`ACS_BIT_DIAG]   = diagnostic_present; // R3
        status_and_control[`ACS_BIT_UNDERV] = undervoltage_flag;  // R5
        status_and_control[`ACS_BIT_PUMP]   = pump_clock_enable;  // R6
        status_and_control[`ACS_BIT_SINGLE] = single_bit_flag;    // R7
        status_and_control[`ACS_BIT_DOUBLE] = double_bit_flag;    // R8
        status_and_control[`ACS_BIT_FIELD]  = field_loss_flag;    // R9
        status_and_control[`ACS_BIT_CRC]    = crc_bad;            // R10
        memory_write_control = 16'h0000; // R11 R21
    end

    // entry window and mode sequence
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            mode      <= MODE_WAIT;
            entry_cnt <= 32'h0;
        end
        else
        begin
            case (mode)
                MODE_WAIT:
                begin
                    entry_cnt <= entry_cnt + 32'h1;
                    if (key_ok)
                        mode <= MODE_CMD; // R1
                    else if (entry_cnt >= 32'(ENTRY_CYCLES - 1))
                        mode <= MODE_NORMAL; // R1
                end
                MODE_NORMAL:
                    // a part stuck in diagnostic mode still accepts the key
                    if (key_ok && diagnostic_present)
                        mode <= MODE_CMD;
                MODE_CMD:
                    mode <= MODE_CMD;
                default:
                    mode <= MODE_WAIT;
            endcase
        end
    end

    // control bits written over the link
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            diagnostic_suppress <= 1'b0; // R4
            pump_clock_enable   <= 1'b0; // R6
            memory_write_enable <= 1'b0; // R11
        end
        else if (take && is_reg && !is_read)
        begin
            // reserved bits of the written word are dropped
            if (cmd_addr == `ACS_ADDR_CTRL)
            begin
                diagnostic_suppress <= cmd_wdata[`ACS_BIT_SUPPRESS]; // R4
                pump_clock_enable   <= cmd_wdata[`ACS_BIT_PUMP];     // R6
            end
            if (cmd_addr == `ACS_ADDR_WCTL)
                memory_write_enable <= cmd_wdata[`ACS_BIT_WREN];     // R11
        end
    end

    // sticky diagnostic flags; only reset clears them
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            undervoltage_flag <= 1'b0;
            single_bit_flag   <= 1'b0;
            double_bit_flag   <= 1'b0;
            field_loss_flag   <= 1'b0;
        end
        else
        begin
            if (undervoltage_in)
                undervoltage_flag <= 1'b1; // R5
            if (field_loss_in)
                field_loss_flag <= 1'b1; // R9
            // every readout is checked, scan or link alike
            if (mem_rvalid && mem_single_err)
                single_bit_flag <= 1'b1; // R7
            if (mem_rvalid && mem_double_err)
                double_bit_flag <= 1'b1; // R8
        end
    end

    // start-up checksum scan over the customer words
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            scan      <= SCAN_ISSUE;
            scan_addr <= `ACS_CUST_FIRST;
            crc       <= `ACS_CRC_INIT; // R18
            crc_bad   <= 1'b0;
        end
        else
        begin
            case (scan)
                SCAN_ISSUE:
                    scan <= SCAN_WAIT;
                SCAN_WAIT:
                    if (mem_rvalid)
                    begin
                        crc <= crc_word(crc, mem_rdata); // R18
                        if (scan_addr == `ACS_CUST_LAST)
                        begin
                            scan    <= SCAN_DONE;
                            // stored checksum folded in must leave zero
                            crc_bad <= crc_word(crc, mem_rdata) != `ACS_CRC_GOOD; // R10
                        end
                        else
                        begin
                            scan      <= SCAN_ISSUE;
                            scan_addr <= scan_addr + 4'h1;
                        end
                    end
                SCAN_DONE:
                    scan <= SCAN_DONE;
                default:
                    scan <= SCAN_DONE;
            endcase
        end
    end

    // memory port: scan reads, link reads and accepted link writes
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            mem_rd    <= 1'b0;
            mem_wr    <= 1'b0;
            mem_addr  <= 4'h0;
            mem_wdata <= 16'h0000;
        end
        else
        begin
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            if (scan == SCAN_ISSUE)
            begin
                mem_rd   <= 1'b1;
                mem_addr <= scan_addr;
            end
            else if (take && is_nvm && is_read)
            begin
                mem_rd   <= 1'b1; // R12
                mem_addr <= cmd_addr;
            end
            // lower half is calibration space, writes there vanish
            else if (take && is_nvm && !is_read && cmd_addr >= `ACS_CUST_FIRST)
            begin
                mem_wr    <= 1'b1; // R12 R13
                mem_addr  <= cmd_addr;
                mem_wdata <= cmd_wdata;
            end
        end
    end

    // programming timer; no lockout, the master must wait it out
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            prog_cnt <= 32'h0;
        else if (mem_wr)
            prog_cnt <= 32'(PROG_CYCLES); // R14 R15
        else if (prog_cnt != 32'h0)
            prog_cnt <= prog_cnt - 32'h1;
    end

    // link answers: register reads next cycle, memory reads on rvalid
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            rsp_valid    <= 1'b0;
            rsp_data     <= 16'h0000;
            link_rd_pend <= 1'b0;
        end
        else
        begin
            rsp_valid <= 1'b0;
            if (take && is_nvm && is_read)
                link_rd_pend <= 1'b1;
            else if (link_rd_pend && mem_rvalid)
            begin
                link_rd_pend <= 1'b0;
                rsp_valid    <= 1'b1;
                rsp_data     <= mem_rdata;
            end
            if (take && is_reg && is_read)
            begin
                rsp_valid <= 1'b1; // R19
                rsp_data  <= (cmd_addr == `ACS_ADDR_CTRL) ? status_and_control :
                             (cmd_addr == `ACS_ADDR_WCTL) ? memory_write_control :
                             16'h0000; // R21
            end
        end
    end

endmodule : acs_cmd_status_regs

// file: src/acs_params.svh
// constants for the angle sensor command/status register bank
// assumes a 50 MHz core clock and a decoded single-wire link transaction port
// Function
// R1: key write in entry window enters command mode
// R2: master writes key command then data early
// R3: diagnostic_present shows live condition, ignores suppress
// R4: diagnostic_suppress writable, cleared at reset
// R5: undervoltage_flag set on low supply
// R6: pump_clock_enable read/write, reset zero
// R7: single-bit flag sticky until reset
// R8: double_bit_flag sticky until reset
// R9: field_loss_flag sticky, diag needs detection enable
// R10: checksum checked at start-up, flag on mismatch
// R11: write enable write-only, reset zero
// R12: command mode reads all, writes customer only
// R13: writes to reserved memory silently dropped
// R14: accepted write starts programming cycle timer
// R15: master avoids memory during programming
// R16: master sets both enables before storing
// R17: master reads words 8..15 for checksum
// R18: crc x8+x2+x+1, preset FF, MSB first
// R19: region 100 selects registers, bit0 read
// R20: command mode disables analog output
// R21: reserved bits read zero, writes ignored
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH

`define ACS_CLK_MHZ        50
`define ACS_REGION_REG     3'h4
`define ACS_REGION_NVM     3'h0
`define ACS_ADDR_CTRL      4'h1
`define ACS_ADDR_KEY       4'hA
`define ACS_ADDR_WCTL      4'hB
`define ACS_KEY_VALUE      16'h16F4
`define ACS_CUST_FIRST     4'h8
`define ACS_CUST_LAST      4'hF
`define ACS_CRC_INIT       8'hFF
`define ACS_CRC_POLY_LOW   8'h07
`define ACS_CRC_GOOD       8'h00
`define ACS_BIT_DIAG       15
`define ACS_BIT_SUPPRESS   14
`define ACS_BIT_UNDERV     12
`define ACS_BIT_PUMP       11
`define ACS_BIT_SINGLE     8
`define ACS_BIT_DOUBLE     7
`define ACS_BIT_FIELD      6
`define ACS_BIT_CRC        4
`define ACS_BIT_WREN       11
`define ACS_ENTRY_TIME_US  1000
`define ACS_PROG_TIME_US   10000

`endif

// file: src/acs_pkg.sv
// types shared by the angle sensor register bank
// assumes acs_params.svh supplies the numeric constants
package acs_pkg;
    // start-up mode sequence
    typedef enum logic [1:0] {MODE_WAIT, MODE_CMD, MODE_NORMAL} acs_mode_t;
    // power-on checksum scan
    typedef enum logic [1:0] {SCAN_ISSUE, SCAN_WAIT, SCAN_DONE} acs_scan_t;
    typedef logic [15:0] acs_word_t;
endpackage : acs_pkg

// file: sim/acs_cmd_status_regs_properties.sv
// port checker for the command/status register bank
// assumes one clock domain and binding onto acs_cmd_status_regs
module acs_csr_props #(
    parameter int ENTRY_TIME_US = 1,
    parameter int PROG_TIME_US  = 1
) (
    // clock and reset
    input wire logic               ref_clk,
    input wire logic               rst,
    // link side
    input wire logic               cmd_valid,
    input wire logic [7:0]         cmd_byte,
    input wire acs_pkg::acs_word_t cmd_wdata,
    input wire logic               rsp_valid,
    // memory side
    input wire logic               mem_rd,
    input wire logic               mem_wr,
    input wire logic [3:0]         mem_addr,
    input wire logic               prog_busy,
    // mode and enables
    input wire logic               command_mode,
    input wire logic               analog_out_enable,
    input wire logic               pump_clock_enable,
    input wire logic               memory_write_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    import acs_pkg::*;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff rst;
    // exact key on the link
    wire logic key_match = cmd_valid && cmd_byte == 8'h94 && cmd_wdata == 16'h16F4;
    // request taken while in command mode
    wire logic cmd_take = cmd_valid && command_mode;
    // accepted customer write: strobe, then programming held
    sequence s_store;
        mem_wr && mem_addr == 4'h9 ##1 prog_busy [*8];
    endsequence
    entry_key_a: assert property ($past(rst) && key_match |=> command_mode)
        else $error("key in window ignored");
    wrong_key_a: assert property (!command_mode && cmd_valid && !key_match |=> !command_mode)
        else $error("entered without key");
    mode_hold_a: assert property (command_mode |=> command_mode)
        else $error("command mode lost");
    analog_off_a: assert property (analog_out_enable != command_mode)
        else $error("analog output wrong");
    reset_zero_a: assert property ($past(rst) |-> !pump_clock_enable && !memory_write_enable)
        else $error("enables not cleared");
    reg_read_a: assert property (cmd_take && cmd_byte == 8'h83 |=> rsp_valid)
        else $error("no register answer");
    mem_read_a: assert property (cmd_take && cmd_byte == 8'h11 |=> mem_rd && mem_addr == 4'h8)
        else $error("memory read not issued");
    drop_rsvd_a: assert property (cmd_take && cmd_byte[7:4] == 4'h0 && !cmd_byte[0] |=> !mem_wr)
        else $error("reserved write reached memory");
    cust_write_a: assert property (cmd_take && cmd_byte == 8'h12 |=> s_store)
        else $error("customer write not programmed");
    pump_write_a: assert property (cmd_take && cmd_byte == 8'h82 |=>
        pump_clock_enable == $past(cmd_wdata[11])) else $error("pump enable not written");
    wren_write_a: assert property (cmd_take && cmd_byte == 8'h96 |=>
        memory_write_enable == $past(cmd_wdata[11])) else $error("write enable not written");
endmodule : acs_csr_props

bind acs_cmd_status_regs acs_csr_props #(
    .ENTRY_TIME_US(ENTRY_TIME_US),
    .PROG_TIME_US (PROG_TIME_US)
) u_props (
    .ref_clk, .rst, .cmd_valid, .cmd_byte, .cmd_wdata, .rsp_valid, .mem_rd, .mem_wr,
    .mem_addr, .prog_busy, .command_mode, .analog_out_enable, .pump_clock_enable,
    .memory_write_enable
);

// file: sim/acs_nvm_model.sv
// behavioural sixteen-word memory behind the register bank
// assumes reads answer three edges after the strobe, writes land at once
module acs_nvm_model (
    // memory port
    input  wire logic        ref_clk,
    input  wire logic        mem_rd,
    input  wire logic        mem_wr,
    input  wire logic [3:0]  mem_addr,
    input  wire logic [15:0] mem_wdata,
    output logic             mem_rvalid,
    output logic [15:0]      mem_rdata,
    output logic             mem_single_err,
    output logic             mem_double_err,
    // fault injection from the bench
    input  wire logic        inj_single,
    input  wire logic        inj_double
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [16];  // cell array
    logic [1:0]  pend;      // read latency pipe
    logic [3:0]  rd_addr;   // captured read address
    // customer words give a zero checksum residue
    logic [15:0] init_w [8] = '{16'h0000, 16'hFFC1, 16'h0400, 16'h0100,
                                16'h1300, 16'h0000, 16'h0000, 16'h00A9};
    // reserved words hold a marker, customer words the sequence
    initial
    begin
        mem = '{default: 16'hC0DE};
        for (int i = 0; i < 8; i++)
            mem[i + 8] = init_w[i];
        pend = 2'h0;
        mem_rdata = 16'h0;
    end
    // no checking of programming time, like the real cells
    always @(posedge ref_clk)
    begin
        if (mem_wr)
            mem[mem_addr] <= mem_wdata;
        if (mem_rd)
            rd_addr <= mem_addr;
        pend <= {pend[0], mem_rd};
        mem_rvalid <= pend[1];
        // idle data toggles so a stale word never looks valid
        mem_rdata <= pend[1] ? mem[rd_addr] : ~mem_rdata;
        mem_single_err <= pend[1] & inj_single;
        mem_double_err <= pend[1] & inj_double;
    end
endmodule : acs_nvm_model

// file: sim/tb_acs_cmd_status_regs.sv
// self-checking bench for the command/status register bank
// assumes entry and programming times shortened to one microsecond
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb_acs_cmd_status_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import acs_pkg::*;
    // one link transaction and the word a read should return
    typedef struct packed {logic [7:0] c; acs_word_t d; acs_word_t e;} acs_row_t;
    localparam acs_row_t ROWS [9] = '{
        '{8'h82, 16'h4800, 16'h0}, '{8'h83, 16'h0, 16'h0800}, '{8'h96, 16'hFFFF, 16'h0},
        '{8'h97, 16'h0, 16'h0}, '{8'h02, 16'h5555, 16'h0}, '{8'h03, 16'h0, 16'hC0DE},
        '{8'h12, 16'hABCD, 16'h0}, '{8'h13, 16'h0, 16'hABCD}, '{8'h11, 16'h0, 16'h0}};
    logic      ref_clk, rst, cmd_valid, rsp_valid, mem_rd, mem_wr, mem_rvalid;
    logic      undervoltage_in, field_loss_in, field_loss_detect_en, inj_single, inj_double;
    logic      mem_single_err, mem_double_err, command_mode, analog_out_enable, prog_busy;
    logic      diag_output_active, pump_clock_enable, memory_write_enable;
    logic [7:0] cmd_byte;
    logic [3:0] mem_addr;
    acs_word_t cmd_wdata, rsp_data, mem_wdata, mem_rdata;
    int        num_errors = 0;  // mismatches
    int        n_tests    = 0;  // comparisons
    int        busy_n     = 0;  // busy cycles seen after the last memory write
    acs_cmd_status_regs #(.ENTRY_TIME_US(1), .PROG_TIME_US(1)) DUT (
        .ref_clk, .rst, .cmd_valid, .cmd_byte, .cmd_wdata, .rsp_valid, .rsp_data,
        .undervoltage_in, .field_loss_in, .field_loss_detect_en, .mem_rd, .mem_wr,
        .mem_addr, .mem_wdata, .mem_rvalid, .mem_rdata, .mem_single_err, .mem_double_err,
        .command_mode, .analog_out_enable, .diag_output_active, .prog_busy,
        .pump_clock_enable, .memory_write_enable);
    acs_nvm_model u_nvm (.ref_clk, .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_rvalid,
        .mem_rdata, .mem_single_err, .mem_double_err, .inj_single, .inj_double);
    // 50 MHz clock
    always #10 ref_clk = ~ref_clk;
    // verdict and end of run
    task automatic give_verdict();
        if (num_errors == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : give_verdict
    // master-side checksum step, nine-bit form with the full generator
    function automatic logic [7:0] crc_step(input logic [7:0] c, input acs_word_t d);
        logic [8:0] s;
        s = {1'b0, c};
        for (int k = 15; k >= 0; k--)
        begin
            s = {s[7:0], d[k]};
            if (s[8])
                s = s ^ 9'h107;
        end
        return s[7:0];
    endfunction : crc_step
    // one link transaction; reads wait for the answer, memory writes for programming
    task automatic xfer(input logic [7:0] c, input acs_word_t d, output acs_word_t r);
        int i;
        cmd_byte = c;
        cmd_wdata = d;
        cmd_valid = 1'b1;
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        for (i = 0; i < 20 && c[0] && rsp_valid !== 1'b1; i++)
            @(negedge ref_clk);
        if (c[0] && i == 20)
            num_errors++;
        r = rsp_data;
        busy_n = 0;
        // no memory access until programming is over
        for (i = 0; i < 200 && c[7:5] == 3'h0 && !c[0] && (i < 3 || prog_busy); i++)
        begin
            if (prog_busy === 1'b1)
                busy_n++;
            @(negedge ref_clk);
        end
        @(negedge ref_clk);
    endtask : xfer
    // hang guard, well past the expected run length
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        num_errors++;
        give_verdict();
    end
    // main sequence
    initial
    begin
        acs_word_t r;
        logic [7:0] c8;
        {ref_clk, rst, cmd_valid, cmd_byte, cmd_wdata} = {2'b01, 25'h0};
        {undervoltage_in, field_loss_in, field_loss_detect_en, inj_single, inj_double} = 5'h0;
        repeat (12) @(negedge ref_clk);
        `CHK(analog_out_enable, 1'b1)
        rst = 1'b0;
        xfer(8'h94, 16'h16F4, r);
        `CHK({command_mode, analog_out_enable}, 2'b10)
        // let the start-up scan finish before memory reads
        repeat (60) @(negedge ref_clk);
        // master reads the customer words back; stored checksum leaves zero
        c8 = 8'hFF;
        for (int a = 8; a < 16; a++)
        begin
            xfer({3'h0, 4'(a), 1'b1}, 16'h0, r);
            c8 = crc_step(c8, r);
        end
        `CHK(c8, 8'h00)
        foreach (ROWS[i])
        begin
            xfer(ROWS[i].c, ROWS[i].d, r);
            if (ROWS[i].c[0])
                `CHK(r, ROWS[i].e)
            // one microsecond of programming at 50 MHz
            if (ROWS[i].c == 8'h12)
                `CHK(busy_n, 50)
        end
        `CHK({pump_clock_enable, memory_write_enable}, 2'b11)
        // every condition at once during one memory readout
        {undervoltage_in, field_loss_in, field_loss_detect_en, inj_single, inj_double} = 5'h1F;
        xfer(8'h11, 16'h0, r);
        {undervoltage_in, field_loss_in, field_loss_detect_en, inj_single, inj_double} = 5'h0;
        xfer(8'h83, 16'h0, r);
        `CHK(r, 16'h99C0)
        `CHK(diag_output_active, 1'b0)
        xfer(8'h82, 16'h0800, r);
        `CHK(diag_output_active, 1'b1)
        // second start-up: the changed customer word breaks the checksum
        rst = 1'b1;
        repeat (12) @(negedge ref_clk);
        rst = 1'b0;
        @(negedge ref_clk);
        `CHK({pump_clock_enable, memory_write_enable}, 2'b00)
        repeat (100) @(negedge ref_clk);
        `CHK(command_mode, 1'b0)
        xfer(8'h94, 16'h0000, r);
        `CHK(command_mode, 1'b0)
        xfer(8'h94, 16'h16F4, r);
        `CHK(command_mode, 1'b1)
        xfer(8'h83, 16'h0, r);
        `CHK(r, 16'h8010)
        give_verdict();
    end
endmodule : tb_acs_cmd_status_regs
